// file: bp_cfg.svh
// constants for the buffer pointer and dma control block
`ifndef BP_CFG_SVH
`define BP_CFG_SVH
// widths
`define BP_PTR_W          16
`define BP_BYTE_W         8
// register addresses
`define BP_ADDR_ASSERT_RST 8'h21
`define BP_ADDR_BUF_CTRL  8'h28
`define BP_ADDR_STP_LO    8'h29
`define BP_ADDR_STP_HI    8'h2A
`define BP_ADDR_RP_LO     8'h2B
`define BP_ADDR_RP_HI     8'h2C
`define BP_ADDR_WP_LO     8'h2D
`define BP_ADDR_WP_HI     8'h2E
`define BP_ADDR_BUF_PORT  8'h2F
`define BP_ADDR_EXT_CTRL  8'h30
// bus reset control bit in register 21
`define BP_BIT_ASSERT_RST 7
// buffer control fields
`define BP_BC_STARTED     7
`define BP_BC_EQUAL       6
`define BP_BC_ATN_INT     4
`define BP_BC_EQ_STOP     3
`define BP_BC_DIR         2
`define BP_BC_DMA_EN      1
`define BP_BC_ACCESS      0
// external control fields
`define BP_EXT_IND        6
`define BP_EXT_GP_MSB     5
`define BP_EXT_GP_LSB     3
`define BP_EXT_ID_MSB     2
// reset values
`define BP_ZERO_BYTE      8'h00
`define BP_SYNC_IDLE_HI   2'h3
`define BP_ID_IDLE_HI     3'h7
`endif

// file: bp_pkg.sv
// shared types and pointer arithmetic for the buffer control block
`include "bp_cfg.svh"
package bp_pkg;
  typedef logic [`BP_PTR_W-1:0]  bp_ptr_t;   // buffer address
  typedef logic [`BP_BYTE_W-1:0] bp_byte_t;  // data byte
  // owner of the latest buffer cycle
  typedef enum logic [1:0] {GR_NONE, GR_PERIPH, GR_SCSI} bp_grant_t;
  // peripheral end sequencer
  typedef enum logic [1:0] {HS_IDLE, HS_REQ} bp_host_st_t;

  typedef struct packed {
    bp_ptr_t ptr;  // live pointer
    bp_ptr_t mon;  // monitor copy seen by reads
  } bp_ptr_state_t;

  typedef struct packed {
    logic [1:0] por_s;     // power-on reset synchroniser
    logic [1:0] drq_s;     // scsi dma request synchroniser
    logic [1:0] brst_s;    // scsi bus reset synchroniser
    logic       brst_d1;   // delayed synced bus reset
    logic [2:0] id_s1;     // id pins, first stage
    logic [2:0] id_s2;     // id pins, second stage
    bp_byte_t   rdata;
    logic       assert_rst;
    logic       started;
    logic       equal;
    logic       atn_int_en;
    logic       eq_stop_en;
    logic       dir;
    logic       dma_en;
    logic       access_mem;
    bp_byte_t   stp_stage;
    bp_ptr_t    stop_pointer;
    logic       indicator;
    logic [2:0] gp_out;
    bp_ptr_t    buf_addr;
    bp_byte_t   buf_wdata;
    logic       buf_we;
    logic       buf_re;
    logic       periph_ack;
    logic       scsi_ack;
    logic       scsi_wait;
    bp_grant_t  grant;
    bp_byte_t   scsi_out;
    logic       eop_n;
    logic       dma_end_set;
    logic       regs_clear;
    logic       rst_irq;
  } bp_dev_state_t;

  typedef struct packed {
    bp_host_st_t st;
    logic        busy;
    logic        req_n;
    bp_byte_t    wdata;
    bp_byte_t    rdata;
    logic        done;
  } bp_host_state_t;

  // next pointer value: byte loads win over an increment, which wraps
  function automatic bp_ptr_t bp_ptr_next(input bp_ptr_t p, input logic ld_lo,
                                          input logic ld_hi, input bp_byte_t b,
                                          input logic inc);
    bp_ptr_t r;
    r = p;
    if (ld_lo || ld_hi) begin
      if (ld_lo) r[`BP_BYTE_W-1:0] = b;
      if (ld_hi) r[`BP_PTR_W-1:`BP_BYTE_W] = b;
    end else if (inc) begin
      r = p + bp_ptr_t'(1);
    end
    return r;
  endfunction : bp_ptr_next
endpackage : bp_pkg

// file: bp_buf_if.sv
// buffer bus and peripheral request carrier between the two ends
`timescale 1ns/1ps
`default_nettype none
interface bp_buf_if;
  import bp_pkg::*;
  bp_ptr_t  buf_addr;          // buffer address
  bp_byte_t buf_wdata;         // buffer write data
  logic     buf_we;            // buffer write cycle
  logic     buf_re;            // buffer read cycle
  bp_byte_t buf_rdata;         // asynchronous memory read data
  logic     periph_request_n;  // peripheral wants a cycle, low active
  bp_byte_t periph_wdata;      // peripheral byte for buffer writes
  logic     periph_ack;        // peripheral cycle granted
  logic     direction;         // one: peripheral writes buffer
  modport dev (
    output buf_addr, buf_wdata, buf_we, buf_re, periph_ack, direction,
    input  buf_rdata, periph_request_n, periph_wdata
  );
  modport periph (
    output periph_request_n, periph_wdata,
    input  periph_ack, direction, buf_rdata
  );
endinterface : bp_buf_if
`default_nettype wire

// file: bp_ptr16.sv
// sixteen-bit buffer pointer with byte loads and a monitor copy
`timescale 1ns/1ps
`default_nettype none
module bp_ptr16 (
  input  wire logic           i_mclk,   // chip clock
  input  wire logic           i_clear,  // synchronous clear
  input  wire logic           i_ld_lo,  // load low byte
  input  wire logic           i_ld_hi,  // load high byte
  input  wire bp_pkg::bp_byte_t i_wbyte,  // byte to load
  input  wire logic           i_inc,    // advance one byte
  input  wire logic           i_snap,   // copy live value to monitor
  output bp_pkg::bp_ptr_t     o_ptr,    // live pointer
  output bp_pkg::bp_ptr_t     o_mon     // monitor copy
);
  import bp_pkg::*;
  bp_ptr_state_t s, n;  // pointer state

  // next state
  always_comb begin
    n = s;
    n.ptr = bp_ptr_next(s.ptr, i_ld_lo, i_ld_hi, i_wbyte, i_inc);
    if (i_snap) n.mon = s.ptr;
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_clear) s <= '0;
    else         s <= n;
  end

  assign o_ptr = s.ptr;
  assign o_mon = s.mon;
endmodule : bp_ptr16
`default_nettype wire

// file: bp_buffer_ctrl.sv
// buffer controller end: pointers, cpu buffer port, arbitration, pins, resets
//
// Functional notes
// - read pointer kept as two bytes
// - write pointer kept as two bytes
// - host halts dma before byte port
// - port read returns byte, bumps read pointer
// - port write stores byte, bumps write pointer
// - indicator bit pulls open-drain pin low
// - three bits drive general outputs high
// - three read-only bits show active ids
// - power-on reset clears all, no bus reset
// - bus reset received: irq, clear 20-27
// - assert bit drives bus reset, clears 20-27
// - simultaneous requests: peripheral goes first
// - peripheral sampled early, dma request late
// - earlier peripheral first, then interleave scsi
// - peripheral synchronous, scsi request resynchronised
// - one source uses read, other write pointer
// - receive reaching stop sets end status
// - pointers advance after every buffer byte
// - direction one reads, zero writes buffer
// - send fetches at read pointer into output
// - receive writes input byte at write pointer
// - pointer reads show monitor, refreshed by control read
// - equal with stop enable strobes end-of-transfer
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bp_cfg.svh"
module bp_buffer_ctrl (
  input  wire logic           i_mclk,              // chip clock, 20 MHz
  input  wire logic           i_srst,              // synchronous reset, high
  input  wire logic           i_power_on_reset_n,  // power-on reset pin, low
  input  wire logic [7:0]     i_reg_addr,          // register address
  input  wire bp_pkg::bp_byte_t i_reg_wdata,       // register write data
  input  wire logic           i_reg_we,            // register write strobe
  input  wire logic           i_reg_re,            // register read strobe
  output bp_pkg::bp_byte_t    o_reg_rdata,         // read data, next cycle
  input  wire logic           i_scsi_dma_request,  // core dma request, async
  output logic                o_scsi_dma_ack,      // core dma acknowledge pulse
  input  wire bp_pkg::bp_byte_t i_scsi_in_data,    // core input data byte
  output bp_pkg::bp_byte_t    o_scsi_out_data,     // core output data latch
  output logic                o_end_of_transfer_n, // end-of-transfer strobe, low
  output logic                o_dma_end_set,       // end-of-dma status set pulse
  input  wire logic           i_scsi_rst_n,        // scsi bus reset in, low, async
  output logic                o_scsi_rst_oe,       // pulls scsi reset low
  output logic                o_scsi_regs_clear,   // clears core registers 20-27
  output logic                o_scsi_reset_irq,    // interrupt pulse on bus reset
  output logic                o_indicator_out_n_oe,// pulls indicator pin low
  output logic [2:0]          o_gp_out,            // general data outputs
  input  wire logic [2:0]     i_id_in_n,           // id inputs, low active, async
  bp_buf_if.dev               bus                  // buffer and peripheral side
);
  import bp_pkg::*;

  bp_dev_state_t s, n;                 // whole block state
  bp_ptr_t  rp, wp, rp_mon, wp_mon;    // pointers and monitors
  logic     rp_ld_lo, rp_ld_hi, rp_inc; // read pointer controls
  logic     wp_ld_lo, wp_ld_hi, wp_inc; // write pointer controls
  logic     snap;                      // monitor refresh
  logic     ptr_clr;                   // pointer clear
  logic     clr_flags;                 // clears started and equal
  logic     periph_req, scsi_req;      // live requests
  logic     cpu_rd_ok, cpu_wr_ok;      // byte port usable
  logic     scsi_rst_now;              // bus reset in or issued
  bp_ptr_t  addr;                      // scsi cycle address
  bp_byte_t rd;                        // read mux

  assign ptr_clr = i_srst | ~s.por_s[1];

  bp_ptr16 u_rp (
    .i_mclk  (i_mclk),
    .i_clear (ptr_clr),
    .i_ld_lo (rp_ld_lo),
    .i_ld_hi (rp_ld_hi),
    .i_wbyte (i_reg_wdata),
    .i_inc   (rp_inc),
    .i_snap  (snap),
    .o_ptr   (rp),
    .o_mon   (rp_mon)
  );

  bp_ptr16 u_wp (
    .i_mclk  (i_mclk),
    .i_clear (ptr_clr),
    .i_ld_lo (wp_ld_lo),
    .i_ld_hi (wp_ld_hi),
    .i_wbyte (i_reg_wdata),
    .i_inc   (wp_inc),
    .i_snap  (snap),
    .o_ptr   (wp),
    .o_mon   (wp_mon)
  );

  // next state of the whole block
  always_comb begin
    n = s;
    rd = `BP_ZERO_BYTE;
    addr = rp;
    {rp_ld_lo, rp_ld_hi, rp_inc, wp_ld_lo, wp_ld_hi, wp_inc} = '0;
    snap = 1'b0;
    clr_flags = 1'b0;
    n.por_s  = {s.por_s[0], i_power_on_reset_n};
    n.drq_s  = {s.drq_s[0], i_scsi_dma_request};
    n.brst_s = {s.brst_s[0], i_scsi_rst_n};
    n.id_s1  = i_id_in_n;
    n.id_s2  = s.id_s1;
    n.brst_d1 = s.brst_s[1];
    // one-cycle outputs fall back
    n.periph_ack = 1'b0;
    n.scsi_ack = 1'b0;
    n.buf_we = 1'b0;
    n.buf_re = 1'b0;
    n.eop_n = 1'b1;
    n.dma_end_set = 1'b0;
    n.rdata = `BP_ZERO_BYTE;
    // port legal only with dma off and matching direction
    cpu_rd_ok = s.access_mem & s.dir & ~s.dma_en;
    cpu_wr_ok = s.access_mem & ~s.dir & ~s.dma_en;

    // register writes
    if (i_reg_we) begin
      case (i_reg_addr)
        `BP_ADDR_ASSERT_RST: n.assert_rst = i_reg_wdata[`BP_BIT_ASSERT_RST];
        `BP_ADDR_BUF_CTRL: begin
          n.atn_int_en = i_reg_wdata[`BP_BC_ATN_INT];
          n.eq_stop_en = i_reg_wdata[`BP_BC_EQ_STOP];
          n.dir        = i_reg_wdata[`BP_BC_DIR];
          n.dma_en     = i_reg_wdata[`BP_BC_DMA_EN];
          n.access_mem = i_reg_wdata[`BP_BC_ACCESS];
          clr_flags    = ~i_reg_wdata[`BP_BC_DMA_EN];
        end
        // low stop byte waits for the high byte
        `BP_ADDR_STP_LO: n.stp_stage = i_reg_wdata;
        `BP_ADDR_STP_HI: begin
          n.stop_pointer = {i_reg_wdata, s.stp_stage};
          clr_flags = 1'b1;
        end
        `BP_ADDR_RP_LO: rp_ld_lo = 1'b1;
        `BP_ADDR_RP_HI: rp_ld_hi = 1'b1;
        `BP_ADDR_WP_LO: wp_ld_lo = 1'b1;
        `BP_ADDR_WP_HI: wp_ld_hi = 1'b1;
        `BP_ADDR_BUF_PORT: begin
          if (cpu_wr_ok) begin
            n.buf_we = 1'b1;
            n.buf_addr = wp;
            n.buf_wdata = i_reg_wdata;
            wp_inc = 1'b1;
          end
        end
        `BP_ADDR_EXT_CTRL: begin
          n.indicator = i_reg_wdata[`BP_EXT_IND];
          n.gp_out = i_reg_wdata[`BP_EXT_GP_MSB:`BP_EXT_GP_LSB];
        end
        default: ;
      endcase
    end

    // register reads, data stands one cycle later
    if (i_reg_re) begin
      case (i_reg_addr)
        `BP_ADDR_ASSERT_RST: rd[`BP_BIT_ASSERT_RST] = s.assert_rst;
        `BP_ADDR_BUF_CTRL: begin
          rd[`BP_BC_STARTED] = s.started;
          rd[`BP_BC_EQUAL]   = s.equal;
          rd[`BP_BC_ATN_INT] = s.atn_int_en;
          rd[`BP_BC_EQ_STOP] = s.eq_stop_en;
          rd[`BP_BC_DIR]     = s.dir;
          rd[`BP_BC_DMA_EN]  = s.dma_en;
          rd[`BP_BC_ACCESS]  = s.access_mem;
          snap = 1'b1;
        end
        `BP_ADDR_STP_LO: rd = s.stop_pointer[`BP_BYTE_W-1:0];
        `BP_ADDR_STP_HI: rd = s.stop_pointer[`BP_PTR_W-1:`BP_BYTE_W];
        `BP_ADDR_RP_LO: rd = rp_mon[`BP_BYTE_W-1:0];
        `BP_ADDR_RP_HI: rd = rp_mon[`BP_PTR_W-1:`BP_BYTE_W];
        `BP_ADDR_WP_LO: rd = wp_mon[`BP_BYTE_W-1:0];
        `BP_ADDR_WP_HI: rd = wp_mon[`BP_PTR_W-1:`BP_BYTE_W];
        `BP_ADDR_BUF_PORT: begin
          // prefetched byte, then bump read pointer
          if (cpu_rd_ok) begin
            rd = bus.buf_rdata;
            rp_inc = 1'b1;
          end
        end
        `BP_ADDR_EXT_CTRL: begin
          rd[`BP_EXT_IND] = s.indicator;
          rd[`BP_EXT_GP_MSB:`BP_EXT_GP_LSB] = s.gp_out;
          rd[`BP_EXT_ID_MSB:0] = ~s.id_s2;
        end
        default: rd = `BP_ZERO_BYTE;
      endcase
    end
    n.rdata = rd;

    // stop-pointer update or dma off clears flags; a set below wins
    if (clr_flags) begin
      n.started = 1'b0;
      n.equal = 1'b0;
    end

    // dma request is dropped by the core after our ack reaches it
    if (s.scsi_wait && !s.drq_s[1]) n.scsi_wait = 1'b0;
    // peripheral taken as driven, dma request after resync
    periph_req = ~bus.periph_request_n & ~s.periph_ack;
    scsi_req = s.drq_s[1] & ~s.scsi_wait;

    if (s.dma_en) begin
      // scsi gets the cycle after a peripheral one
      if (scsi_req && (!periph_req || s.grant == GR_PERIPH)) begin
        n.grant = GR_SCSI;
        n.scsi_ack = 1'b1;
        n.scsi_wait = 1'b1;
        n.started = 1'b1;
        // scsi: read pointer on send, write pointer on receive
        addr = s.dir ? rp : wp;
        n.buf_addr = addr;
        if (s.dir) begin
          n.buf_re = 1'b1;
          rp_inc = 1'b1;
        end else begin
          n.buf_we = 1'b1;
          n.buf_wdata = i_scsi_in_data;
          wp_inc = 1'b1;
        end
        if (addr == s.stop_pointer) begin
          n.equal = 1'b1;
          if (s.eq_stop_en) n.eop_n = 1'b0;
          if (!s.dir) n.dma_end_set = 1'b1;
        end
      end else if (periph_req) begin
        n.grant = GR_PERIPH;
        n.periph_ack = 1'b1;
        if (s.dir) begin
          n.buf_we = 1'b1;
          n.buf_addr = wp;
          n.buf_wdata = bus.periph_wdata;
          wp_inc = 1'b1;
        end else begin
          n.buf_re = 1'b1;
          n.buf_addr = rp;
          rp_inc = 1'b1;
        end
      end
    end else if (cpu_rd_ok) begin
      // keep the next read byte ready on the async memory
      n.buf_re = 1'b1;
      n.buf_addr = bp_ptr_next(rp, rp_ld_lo, rp_ld_hi, i_reg_wdata, rp_inc);
    end

    // latch the fetched byte for the core
    if (s.scsi_ack && s.dir) n.scsi_out = bus.buf_rdata;

    // irq on a received bus reset edge
    n.rst_irq = s.brst_d1 & ~s.brst_s[1];
    // issued or received reset clears 20-27, assert bit kept
    scsi_rst_now = ~s.brst_s[1] | s.assert_rst;
    n.regs_clear = scsi_rst_now;
    if (scsi_rst_now) n.scsi_out = `BP_ZERO_BYTE;

    // power-on reset clears all but the synchronisers
    if (!s.por_s[1]) begin
      n = '0;
      n.por_s = {s.por_s[0], i_power_on_reset_n};
      n.drq_s = {s.drq_s[0], i_scsi_dma_request};
      n.brst_s = {s.brst_s[0], i_scsi_rst_n};
      n.brst_d1 = s.brst_s[1];
      n.id_s1 = i_id_in_n;
      n.id_s2 = s.id_s1;
      n.eop_n = 1'b1;
    end
  end

  // state register; synchronisers park on the idle level
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s <= '0;
      s.por_s <= `BP_SYNC_IDLE_HI;
      s.brst_s <= `BP_SYNC_IDLE_HI;
      s.brst_d1 <= 1'b1;
      // id pins idle high, so no id reads active straight after reset
      s.id_s1 <= `BP_ID_IDLE_HI;
      s.id_s2 <= `BP_ID_IDLE_HI;
      s.eop_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign o_reg_rdata = s.rdata;
  assign o_scsi_dma_ack = s.scsi_ack;
  assign o_scsi_out_data = s.scsi_out;
  assign o_end_of_transfer_n = s.eop_n;
  assign o_dma_end_set = s.dma_end_set;
  assign o_scsi_rst_oe = s.assert_rst;
  assign o_scsi_regs_clear = s.regs_clear;
  assign o_scsi_reset_irq = s.rst_irq;
  assign o_indicator_out_n_oe = s.indicator;
  assign o_gp_out = s.gp_out;
  assign bus.buf_addr = s.buf_addr;
  assign bus.buf_wdata = s.buf_wdata;
  assign bus.buf_we = s.buf_we;
  assign bus.buf_re = s.buf_re;
  assign bus.periph_ack = s.periph_ack;
  assign bus.direction = s.dir;
endmodule : bp_buffer_ctrl
`default_nettype wire

// file: bp_periph_end.sv
// peripheral controller end: one buffer byte per request
`timescale 1ns/1ps
`default_nettype none
module bp_periph_end (
  input  wire logic           i_mclk,   // chip clock
  input  wire logic           i_srst,   // synchronous reset, high
  input  wire logic           i_start,  // start one byte transfer
  input  wire bp_pkg::bp_byte_t i_wdata,  // byte for a buffer write
  output logic                o_busy,   // transfer in flight
  output bp_pkg::bp_byte_t    o_rdata,  // byte from a buffer read
  output logic                o_done,   // transfer finished pulse
  bp_buf_if.periph            bus       // request side
);
  import bp_pkg::*;
  bp_host_state_t s, n;  // sequencer state

  // request until acknowledged
  always_comb begin
    n = s;
    n.done = 1'b0;
    case (s.st)
      HS_IDLE: begin
        // request driven from our own clock
        if (i_start) begin
          n.st = HS_REQ;
          n.busy = 1'b1;
          n.req_n = 1'b0;
          n.wdata = i_wdata;
        end
      end
      HS_REQ: begin
        // drop at once so the grant is not repeated
        if (bus.periph_ack) begin
          n.st = HS_IDLE;
          n.busy = 1'b0;
          n.req_n = 1'b1;
          n.done = 1'b1;
          // direction zero means we read the buffer
          if (!bus.direction) n.rdata = bus.buf_rdata;
        end
      end
      default: n.st = HS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s <= '0;
      s.req_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign o_busy = s.busy;
  assign o_rdata = s.rdata;
  assign o_done = s.done;
  assign bus.periph_request_n = s.req_n;
  assign bus.periph_wdata = s.wdata;
endmodule : bp_periph_end
`default_nettype wire

// file: bp_link_assertions.sv
// protocol checks on the buffer link between controller and peripheral end
`timescale 1ns/1ps
`default_nettype none
module bp_link_assertions (
  input wire logic             i_mclk,           // chip clock
  input wire logic             i_srst,           // sync reset, high
  input wire bp_pkg::bp_byte_t buf_wdata,        // buffer write data
  input wire logic             buf_we,           // buffer write cycle
  input wire logic             buf_re,           // buffer read cycle
  input wire logic             periph_request_n, // peripheral request, low
  input wire bp_pkg::bp_byte_t periph_wdata,     // peripheral byte
  input wire logic             periph_ack,       // peripheral grant
  input wire logic             direction         // direction bit
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  chk_ack_pulse: assert property (periph_ack |=> !periph_ack)
    else $error("peripheral ack longer than one cycle");
  chk_ack_cause: assert property (periph_ack |-> $past(periph_request_n) == 1'b0)
    else $error("peripheral ack without request");
  // bench only requests with transfers enabled, so a grant comes soon
  chk_req_bound: assert property ($fell(periph_request_n) |-> ##[1:20] periph_ack)
    else $error("peripheral request never served");
  chk_req_hold: assert property (!periph_request_n && !periph_ack |=> !periph_request_n)
    else $error("request dropped before ack");
  chk_req_drop: assert property (periph_ack |=> periph_request_n)
    else $error("request still low after ack");
  chk_wdata_hold: assert property (!periph_request_n && !periph_ack |=> $stable(periph_wdata))
    else $error("peripheral byte changed while waiting");
  chk_periph_write: assert property (periph_ack && direction |->
    buf_we && !buf_re && buf_wdata == periph_wdata)
    else $error("peripheral write cycle wrong");
  chk_periph_read: assert property (periph_ack && !direction |-> buf_re && !buf_we)
    else $error("peripheral read cycle wrong");
  chk_we_owner: assert property (buf_we && direction |-> periph_ack)
    else $error("buffer written by wrong source");
endmodule : bp_link_assertions
`default_nettype wire

// file: buffer_pointer_dma_control_bench.sv
// self-checking bench: controller and peripheral end joined over the link
`timescale 1ns/1ps
`default_nettype none
module buffer_pointer_dma_control_bench;
  import bp_pkg::*;
  logic       i_mclk, i_srst, por_n, we, re, scsi_dma_request, rst_n, st;  // driven inputs
  logic [7:0] addr;                                           // register address
  bp_byte_t   wd, pwd, rdata, sout, prd;                      // data bytes
  logic       ack, eop_n, dend, rst_oe, rclr, rirq, ind_oe;   // controller outputs
  logic [2:0] gp;                                             // general outputs
  logic       pbusy, pdone;                                   // peripheral end status
  bp_byte_t   mem [0:65535];                                  // asynchronous buffer
  int         err_total, tests_run, tp, ts, k;                // counters
  bp_buf_if bus_if ();
  // memory reads settle at once, writes land on the closing edge
  assign bus_if.buf_rdata = mem[bus_if.buf_addr];
  always @(posedge i_mclk) if (bus_if.buf_we) mem[bus_if.buf_addr] <= bus_if.buf_wdata;
  bp_buffer_ctrl i_bp_buffer_ctrl (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_power_on_reset_n(por_n), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_we(we),
    .i_reg_re(re), .o_reg_rdata(rdata), .i_scsi_dma_request(scsi_dma_request), .o_scsi_dma_ack(ack),
    .i_scsi_in_data(8'hC3), .o_scsi_out_data(sout), .o_end_of_transfer_n(eop_n),
    .o_dma_end_set(dend), .i_scsi_rst_n(rst_n), .o_scsi_rst_oe(rst_oe),
    .o_scsi_regs_clear(rclr), .o_scsi_reset_irq(rirq), .o_indicator_out_n_oe(ind_oe),
    .o_gp_out(gp), .i_id_in_n(3'b101), .bus(bus_if.dev));
  bp_periph_end i_bp_periph_end (.i_mclk(i_mclk), .i_srst(i_srst), .i_start(st),
    .i_wdata(pwd), .o_busy(pbusy), .o_rdata(prd), .o_done(pdone), .bus(bus_if.periph));
  bp_link_assertions i_bp_link_assertions (.i_mclk(i_mclk), .i_srst(i_srst),
    .buf_wdata(bus_if.buf_wdata), .buf_we(bus_if.buf_we), .buf_re(bus_if.buf_re),
    .periph_request_n(bus_if.periph_request_n), .periph_wdata(bus_if.periph_wdata),
    .periph_ack(bus_if.periph_ack), .direction(bus_if.direction));
  // 20 MHz chip clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge i_mclk);
    we <= 1'b0;
  endtask : wr
  // one-cycle read, data looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    addr <= a;
    re <= 1'b1;
    @(posedge i_mclk);
    re <= 1'b0;
    #1;
    chk(rdata, e, "register read");
  endtask : rd
  // let edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic results;
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // watchdog, far beyond the under two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge i_mclk);
    err_total++;
    results();
  end
  initial begin
    {i_srst, por_n, rst_n} = 3'b111;
    {we, re, scsi_dma_request, st} = 4'h0;
    addr = 8'h00;
    wd = 8'h00;
    pwd = 8'h00;
    err_total = 0;
    tests_run = 0;
    tp = -1;
    ts = -1;
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    // id pins need two edges through their synchroniser
    tick(1);
    rd(8'h30, 8'h02);
    // output pins and read-only id bits
    wr(8'h30, 8'hFF);
    tick(1);
    chk(8'(gp), 8'h07, "gp outputs");
    chk(8'(ind_oe), 8'h01, "indicator");
    rd(8'h30, 8'h7A);
    wr(8'h30, 8'h28);
    tick(1);
    chk(8'(gp), 8'h05, "gp outputs");
    chk(8'(ind_oe), 8'h00, "indicator");
    // cpu writes across the top of the buffer
    wr(8'h2D, 8'hFF);
    wr(8'h2E, 8'hFF);
    wr(8'h28, 8'h01);
    wr(8'h2F, 8'hA5);
    wr(8'h2F, 8'h5A);
    tick(1);
    chk(mem[16'hFFFF], 8'hA5, "port write");
    chk(mem[16'h0000], 8'h5A, "port write wrap");
    // monitor copy refreshes only on a control read
    rd(8'h2D, 8'h00);
    rd(8'h28, 8'h01);
    rd(8'h2D, 8'h01);
    rd(8'h2E, 8'h00);
    // cpu reads across the top, then an unmapped place
    wr(8'h2B, 8'hFF);
    wr(8'h2C, 8'hFF);
    wr(8'h28, 8'h05);
    rd(8'h2F, 8'hA5);
    rd(8'h2F, 8'h5A);
    wr(8'h40, 8'h11);
    rd(8'h40, 8'h00);
    // send with a peripheral write racing it
    wr(8'h2B, 8'h00);
    wr(8'h2C, 8'h00);
    wr(8'h2D, 8'h10);
    wr(8'h2E, 8'h00);
    wr(8'h28, 8'h06);
    @(posedge i_mclk);
    scsi_dma_request <= 1'b1;
    st <= 1'b1;
    pwd <= 8'h3C;
    @(posedge i_mclk);
    st <= 1'b0;
    for (k = 0; k < 30; k++) begin
      tick(1);
      if (bus_if.periph_ack === 1'b1 && tp < 0) tp = k;
      if (ack === 1'b1 && ts < 0) ts = k;
    end
    chk(8'(tp >= 0 && ts > tp), 8'h01, "peripheral first");
    @(posedge i_mclk);
    scsi_dma_request <= 1'b0;
    tick(3);
    chk(sout, 8'h5A, "send byte");
    chk(mem[16'h0010], 8'h3C, "peripheral byte");
    // receive ending on the stop pointer, peripheral reading beside it
    wr(8'h29, 8'h11);
    wr(8'h2A, 8'h00);
    wr(8'h2B, 8'h10);
    wr(8'h28, 8'h0A);
    @(posedge i_mclk);
    scsi_dma_request <= 1'b1;
    st <= 1'b1;
    @(posedge i_mclk);
    st <= 1'b0;
    for (k = 0; k < 20 && ack !== 1'b1; k++) tick(1);
    chk(8'(eop_n), 8'h00, "end strobe");
    chk(8'(dend), 8'h01, "end status");
    chk(prd, 8'h3C, "peripheral read");
    chk(8'({pbusy, pdone}), 8'h01, "peripheral done");
    @(posedge i_mclk);
    scsi_dma_request <= 1'b0;
    tick(3);
    chk(mem[16'h0011], 8'hC3, "receive byte");
    rd(8'h28, 8'hCA);
    rd(8'h2D, 8'h12);
    rd(8'h2B, 8'h11);
    // bus reset issued, then received
    wr(8'h21, 8'h80);
    tick(2);
    chk(8'({rst_oe, rclr}), 8'h03, "assert reset");
    @(posedge i_mclk);
    rst_n <= 1'b0;
    for (k = 0; k < 10 && rirq !== 1'b1; k++) tick(1);
    chk(8'({rirq, rclr}), 8'h03, "bus reset in");
    @(posedge i_mclk);
    rst_n <= 1'b1;
    tick(4);
    rd(8'h21, 8'h80);
    wr(8'h21, 8'h00);
    tick(2);
    chk(8'(rst_oe), 8'h00, "release reset");
    // power-on reset clears all and ends the bus reset
    wr(8'h21, 8'h80);
    @(posedge i_mclk);
    por_n <= 1'b0;
    tick(4);
    chk(8'({rst_oe, gp}), 8'h00, "power-on reset");
    @(posedge i_mclk);
    por_n <= 1'b1;
    tick(3);
    rd(8'h30, 8'h02);
    rd(8'h28, 8'h00);
    results();
  end
endmodule : buffer_pointer_dma_control_bench
`default_nettype wire
